// ---- logic/wdg_pkg.sv ----
// constants, register map and state record of the windowed watchdog
// assumes a 40 MHz core clock and a word-wide AHB-Lite slave port
//
// Overview of operation
// - period code picks 2^18..2^24 gear or 2^11..2^17 slow-clock cycles
// - action bit 0 raises interrupt request, 1 raises reset request
// - window, period and action fields ignore writes while enabled
// - the write that sets enable from 0 also loads the fields
// - setup register reads bit 7 as one and bit 6 as zero
// - code 0x4E zeroes the counter, counting goes on; unknown codes ignored
// - code 0xB1 stops and zeroes the counter only when enable is 0
// - code port is write-only, resets to zero; no read-modify-write
// - count monitor returns the live counter, zero after reset
// - overflow interrupt sets the overflow cause flag
// - clear outside the window sets the window violation flag
// - operating flag reads one while running, zero while stopped
// - any status read clears both cause flags
// - status bits 7 to 3 always read their reset values
// - enable starts counting, stop zeroes counter, restart needs no code
// - early clear with nonzero window raises interrupt, counter not cleared
// - clear and overflow together: clear wins, no overflow event
// - counter holds during stop, idle and sleep, then resumes
package wdg_pkg;

  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [15:0] IDX_SETUP  = 16'h0FD4;
  localparam logic [15:0] IDX_CODE   = 16'h0FD5;
  localparam logic [15:0] IDX_COUNT  = 16'h0FD6;
  localparam logic [15:0] IDX_STATE  = 16'h0FD7;

  // ==========================================================
  // setup field positions and reset values
  localparam int          SETUP_EN_BIT   = 5;
  localparam int          SETUP_WIN_LSB  = 3;
  localparam int          SETUP_PER_LSB  = 1;
  localparam int          SETUP_ACT_BIT  = 0;
  localparam logic        RST_EN         = 1'b1;
  localparam logic [1:0]  RST_WIN        = 2'b00;
  localparam logic [1:0]  RST_PER        = 2'b11;
  localparam logic        RST_ACT        = 1'b0;
  localparam logic [1:0]  SETUP_FIXED_HI = 2'b10;
  localparam logic [4:0]  STATE_FIXED_HI = 5'b00001;
  localparam logic [7:0]  RST_CODE       = 8'h00;

  // ==========================================================
  // control codes
  localparam logic [7:0]  CODE_CLEAR     = 8'h4E;
  localparam logic [7:0]  CODE_DISABLE   = 8'hB1;

  // ==========================================================
  // counting: period exponent of code 00, and the counter width
  localparam int          GEAR_EXP0      = 18;
  localparam int          SLOW_EXP0      = 11;
  localparam int          CNT_BITS       = 8;
  localparam logic [4:0]  GEAR_SHIFT0    = 5'(GEAR_EXP0 - CNT_BITS);
  localparam logic [4:0]  SLOW_SHIFT0    = 5'(SLOW_EXP0 - CNT_BITS);
  localparam int          PRE_BITS       = 16;

  typedef enum logic [1:0] {
    WDG_STOPPED = 2'b01,
    WDG_RUNNING = 2'b10
  } wdg_mode_t;

  typedef struct packed {
    wdg_mode_t              mode;
    logic                   en;
    logic [1:0]             win;
    logic [1:0]             per;
    logic                   act;
    logic [CNT_BITS-1:0]    cnt;
    logic [PRE_BITS-1:0]    pre;
    logic                   ovf_flag;
    logic                   win_flag;
    logic                   nmi;
    logic                   rst_req;
    logic [7:0]             code;
    logic                   ph_wr;
    logic [1:0]             ph_sel;
    logic [7:0]             rdata;
    logic [2:0]             sync;
    logic                   lf_lvl;
  } wdg_state_t;

endpackage

// ---- logic/wdg_top.sv ----
// windowed watchdog: setup, control codes, counter, status flags
// assumes a single AHB-Lite master, gear tick and hold from core logic,
// and the slow clock arriving as an unsynchronised pin
`timescale 1ns/1ps
`default_nettype none
module wdg_top (
  input  wire logic        CORE_CLK_IN,
  input  wire logic        SYS_RST_IN,
  input  wire logic        AHB_HSEL_IN,
  input  wire logic [31:0] AHB_HADDR_IN,
  input  wire logic [1:0]  AHB_HTRANS_IN,
  input  wire logic        AHB_HWRITE_IN,
  input  wire logic [2:0]  AHB_HSIZE_IN,
  input  wire logic [31:0] AHB_HWDATA_IN,
  input  wire logic        AHB_HREADY_IN,
  output logic      [31:0] AHB_HRDATA_OUT,
  output logic             AHB_HREADYOUT_OUT,
  output logic             AHB_HRESP_OUT,
  input  wire logic        GEAR_TICK_IN,
  input  wire logic        LOW_FREQ_CLOCK_IN,
  input  wire logic        SLOW_SOURCE_SEL_IN,
  input  wire logic        LOW_POWER_HOLD_IN,
  output logic             WDG_NMI_REQ_OUT,
  output logic             WDG_RESET_REQ_OUT,
  output logic             WDG_RUNNING_OUT
);

  wdg_pkg::wdg_state_t st_reg;
  wdg_pkg::wdg_state_t st_next;

  // ==========================================================
  // bus decode
  logic        acc;
  logic        hit;
  logic [1:0]  sel;
  logic        rd_state;
  logic [13:0] base_w;
  logic [7:0]  wd;

  assign acc = AHB_HSEL_IN & AHB_HREADY_IN & AHB_HTRANS_IN[1];
  // the four indices share all but the two low bits
  assign base_w = wdg_pkg::IDX_SETUP[15:2];
  assign hit = (AHB_HADDR_IN[31:18] == 14'h0000) &&
               (AHB_HADDR_IN[17:4] == base_w) &&
               (AHB_HADDR_IN[1:0] == 2'b00);
  assign sel = AHB_HADDR_IN[3:2];
  assign rd_state = acc & hit & ~AHB_HWRITE_IN &
                    (sel == wdg_pkg::IDX_STATE[1:0]);
  assign wd = AHB_HWDATA_IN[7:0];

  // ==========================================================
  // counting source and prescaler
  logic        lf_rise;
  logic        src_tick;
  logic [4:0]  shift;
  logic [15:0] mask;
  logic        step;
  logic        running;

  assign lf_rise = (st_reg.sync[1] == st_reg.sync[2]) &&
                   st_reg.sync[2] && !st_reg.lf_lvl;
  assign src_tick = SLOW_SOURCE_SEL_IN ? lf_rise : GEAR_TICK_IN;
  assign shift = (SLOW_SOURCE_SEL_IN ? wdg_pkg::SLOW_SHIFT0
                                     : wdg_pkg::GEAR_SHIFT0)
                 + {2'b00, st_reg.per, 1'b0};
  assign mask = 16'((32'h0000_0001 << shift) - 32'h0000_0001);
  assign running = (st_reg.mode == wdg_pkg::WDG_RUNNING);
  assign step = running & ~LOW_POWER_HOLD_IN & src_tick &
                ((st_reg.pre & mask) == mask);

  // ==========================================================
  // data-phase writes of setup and control codes
  logic wr;
  logic wr_setup;
  logic wr_code;
  logic clr_try;
  logic clr_early;
  logic clr_ok;
  logic stop;
  logic ovf;

  assign wr = st_reg.ph_wr;
  assign wr_setup = wr && (st_reg.ph_sel == wdg_pkg::IDX_SETUP[1:0]);
  assign wr_code = wr && (st_reg.ph_sel == wdg_pkg::IDX_CODE[1:0]);
  assign clr_try = wr_code && (wd == wdg_pkg::CODE_CLEAR) && running;
  // window codes are quarters of the 256-step period
  assign clr_early = (st_reg.win != 2'b00) &&
                     (st_reg.cnt < {st_reg.win, 6'h00});
  assign clr_ok = clr_try & ~clr_early;
  assign stop = wr_code && (wd == wdg_pkg::CODE_DISABLE) &&
                !st_reg.en;
  // a clear or a stop in the same cycle swallows the overflow
  assign ovf = step && (st_reg.cnt == 8'hFF) && !clr_ok && !stop;

  // ==========================================================
  // next state
  always_comb begin
    st_next = st_reg;
    st_next.nmi = 1'b0;
    st_next.rst_req = 1'b0;

    // slow clock pin: three flops, a change counts when 2nd and 3rd agree
    st_next.sync = {st_reg.sync[1:0], LOW_FREQ_CLOCK_IN};
    if (st_reg.sync[1] == st_reg.sync[2]) begin
      st_next.lf_lvl = st_reg.sync[2];
    end

    if (running && !LOW_POWER_HOLD_IN && src_tick) begin
      st_next.pre = st_reg.pre + 16'h0001;
    end
    if (step) begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end

    if (wr_setup) begin
      st_next.en = wd[wdg_pkg::SETUP_EN_BIT];
      if (!st_reg.en) begin
        // fields load only while unlocked, which covers the enabling write
        st_next.win = wd[wdg_pkg::SETUP_WIN_LSB +: 2];
        st_next.per = wd[wdg_pkg::SETUP_PER_LSB +: 2];
        st_next.act = wd[wdg_pkg::SETUP_ACT_BIT];
        if (wd[wdg_pkg::SETUP_EN_BIT]) begin
          st_next.mode = wdg_pkg::WDG_RUNNING;
        end
      end // else fields stay put
    end

    if (wr_code) begin
      st_next.code = wd;
    end
    if (clr_ok) begin
      st_next.cnt = 8'h00;
      st_next.pre = 16'h0000;
    end
    if (stop) begin
      st_next.mode = wdg_pkg::WDG_STOPPED;
      st_next.cnt = 8'h00;
      st_next.pre = 16'h0000;
    end

    // overflow wraps the counter and keeps counting for either action
    if (ovf && st_reg.act) begin
      st_next.rst_req = 1'b1;
    end
    if (ovf && !st_reg.act) begin
      st_next.nmi = 1'b1;
    end
    if (clr_try && clr_early) begin
      st_next.nmi = 1'b1;
    end

    // a set arriving with the read that clears still wins
    st_next.ovf_flag = (st_reg.ovf_flag & ~rd_state) |
                       (ovf & ~st_reg.act);
    st_next.win_flag = (st_reg.win_flag & ~rd_state) |
                       (clr_try & clr_early);

    // address phase: latch write target, fetch read data now so that
    // hrdata comes straight from a flop in the data phase
    st_next.ph_wr = acc & hit & AHB_HWRITE_IN;
    st_next.ph_sel = sel;
    st_next.rdata = 8'h00;
    if (acc && hit && !AHB_HWRITE_IN) begin
      case (sel)
        wdg_pkg::IDX_SETUP[1:0]: begin
          st_next.rdata = {wdg_pkg::SETUP_FIXED_HI, st_reg.en,
                           st_reg.win, st_reg.per, st_reg.act};
        end
        wdg_pkg::IDX_CODE[1:0]: begin
          st_next.rdata = 8'h00;
        end
        wdg_pkg::IDX_COUNT[1:0]: begin
          st_next.rdata = st_reg.cnt;
        end
        wdg_pkg::IDX_STATE[1:0]: begin
          st_next.rdata = {wdg_pkg::STATE_FIXED_HI, st_reg.ovf_flag,
                           st_reg.win_flag, running};
        end
        default: begin
          st_next.rdata = 8'h00;
        end
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      st_reg.mode     <= wdg_pkg::WDG_RUNNING;
      st_reg.en       <= wdg_pkg::RST_EN;
      st_reg.win      <= wdg_pkg::RST_WIN;
      st_reg.per      <= wdg_pkg::RST_PER;
      st_reg.act      <= wdg_pkg::RST_ACT;
      st_reg.cnt      <= 8'h00;
      st_reg.pre      <= 16'h0000;
      st_reg.ovf_flag <= 1'b0;
      st_reg.win_flag <= 1'b0;
      st_reg.nmi      <= 1'b0;
      st_reg.rst_req  <= 1'b0;
      st_reg.code     <= wdg_pkg::RST_CODE;
      st_reg.ph_wr    <= 1'b0;
      st_reg.ph_sel   <= 2'b00;
      st_reg.rdata    <= 8'h00;
      st_reg.sync     <= 3'b000;
      st_reg.lf_lvl   <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  assign AHB_HRDATA_OUT    = {24'h00_0000, st_reg.rdata};
  assign AHB_HREADYOUT_OUT = 1'b1;
  assign AHB_HRESP_OUT     = 1'b0;
  assign WDG_NMI_REQ_OUT   = st_reg.nmi;
  assign WDG_RESET_REQ_OUT = st_reg.rst_req;
  assign WDG_RUNNING_OUT   = running;

endmodule
`default_nettype wire

// ---- dv/wdg_props.sv ----
// checker of the watchdog read replies and request pulses
// assumes it is bound to wdg_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module wdg_props (
  input wire logic        CORE_CLK_IN,
  input wire logic        SYS_RST_IN,
  input wire logic        AHB_HSEL_IN,
  input wire logic [31:0] AHB_HADDR_IN,
  input wire logic [1:0]  AHB_HTRANS_IN,
  input wire logic        AHB_HWRITE_IN,
  input wire logic        AHB_HREADY_IN,
  input wire logic [31:0] AHB_HRDATA_OUT,
  input wire logic        WDG_NMI_REQ_OUT,
  input wire logic        WDG_RESET_REQ_OUT,
  input wire logic        WDG_RUNNING_OUT
);
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  // ==========================================================
  // read address phase of one register
  sequence s_rd(logic [15:0] idx);
    AHB_HSEL_IN && AHB_HREADY_IN && AHB_HTRANS_IN[1] && !AHB_HWRITE_IN
      && AHB_HADDR_IN == {14'h0000, idx, 2'b00};
  endsequence
  // ==========================================================
  // assertions
  a_setup_fixed: assert property (s_rd(wdg_pkg::IDX_SETUP) |=>
    AHB_HRDATA_OUT[31:6] == {24'h00_0000, wdg_pkg::SETUP_FIXED_HI})
    else $error("setup fixed bits wrong");
  a_state_fixed: assert property (s_rd(wdg_pkg::IDX_STATE) |=>
    AHB_HRDATA_OUT[31:3] == {24'h00_0000, wdg_pkg::STATE_FIXED_HI})
    else $error("status fixed bits wrong");
  a_state_run: assert property (s_rd(wdg_pkg::IDX_STATE) |=>
    AHB_HRDATA_OUT[0] == $past(WDG_RUNNING_OUT))
    else $error("status running bit wrong");
  a_code_wo: assert property (s_rd(wdg_pkg::IDX_CODE) |=>
    AHB_HRDATA_OUT == 32'h0000_0000) else $error("code port readable");
  // a stopped watchdog always holds a zero count
  a_stop_zero: assert property (
    s_rd(wdg_pkg::IDX_COUNT) ##0 !WDG_RUNNING_OUT |=>
    AHB_HRDATA_OUT == 32'h0000_0000) else $error("stopped count not zero");
  a_nmi_pulse: assert property (
    WDG_NMI_REQ_OUT |=> !WDG_NMI_REQ_OUT) else $error("interrupt not a pulse");
  a_req_excl: assert property (
    !(WDG_NMI_REQ_OUT && WDG_RESET_REQ_OUT)) else $error("both requests");
  a_stop_quiet: assert property (
    !WDG_RUNNING_OUT && !$past(WDG_RUNNING_OUT) |->
    !WDG_NMI_REQ_OUT && !WDG_RESET_REQ_OUT)
    else $error("request while stopped");
endmodule
bind wdg_top wdg_props u_props (
  .CORE_CLK_IN(CORE_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .AHB_HSEL_IN(AHB_HSEL_IN), .AHB_HADDR_IN(AHB_HADDR_IN),
  .AHB_HTRANS_IN(AHB_HTRANS_IN), .AHB_HWRITE_IN(AHB_HWRITE_IN),
  .AHB_HREADY_IN(AHB_HREADY_IN), .AHB_HRDATA_OUT(AHB_HRDATA_OUT),
  .WDG_NMI_REQ_OUT(WDG_NMI_REQ_OUT), .WDG_RESET_REQ_OUT(WDG_RESET_REQ_OUT),
  .WDG_RUNNING_OUT(WDG_RUNNING_OUT));
`default_nettype wire

// ---- dv/windowed_watchdog_control_bench.sv ----
// self-checking bench of the windowed watchdog over its bus port
// assumes wdg_top; the slow clock is made here at a quarter core rate
`timescale 1ns/1ps
`default_nettype none
module windowed_watchdog_control_bench;
  logic             clk      = 1'b0;
  logic             rst      = 1'b1;
  logic             hsel     = 1'b0;
  logic [31:0]      haddr    = 32'h0000_0000;
  logic [1:0]       htrans   = 2'b00;
  logic             hwrite   = 1'b0;
  logic [31:0]      hwdata   = 32'h0000_0000;
  logic             lf       = 1'b0;
  logic             slow_sel = 1'b1;
  logic             hold     = 1'b0;
  logic [31:0]      seed     = 32'h0000_001D;
  logic [31:0]      v;
  logic [31:0]      q;
  wire logic [31:0] hrdata;
  wire logic        hready, hresp, nmi, rreq, running;
  int               err_total = 0, compares = 0, nmi_cnt = 0, rst_cnt = 0;
  int               cyc = 0, gap = 0, last = 0, n0;
  wdg_top DUT (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .AHB_HSEL_IN(hsel),
    .AHB_HADDR_IN(haddr), .AHB_HTRANS_IN(htrans), .AHB_HWRITE_IN(hwrite),
    .AHB_HSIZE_IN(3'h2), .AHB_HWDATA_IN(hwdata), .AHB_HREADY_IN(hready),
    .AHB_HRDATA_OUT(hrdata), .AHB_HREADYOUT_OUT(hready),
    .AHB_HRESP_OUT(hresp), .GEAR_TICK_IN(1'b1), .LOW_FREQ_CLOCK_IN(lf),
    .SLOW_SOURCE_SEL_IN(slow_sel), .LOW_POWER_HOLD_IN(hold),
    .WDG_NMI_REQ_OUT(nmi), .WDG_RESET_REQ_OUT(rreq),
    .WDG_RUNNING_OUT(running));
  // ==========================================================
  // clocks, event counters, expectations
  initial forever #12.5 clk = ~clk;
  initial forever begin
    repeat (2) @(posedge clk);
    lf <= ~lf;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (nmi === 1'b1) begin
      nmi_cnt <= nmi_cnt + 1;
      gap <= cyc - last;
      last <= cyc;
    end
    if (rreq === 1'b1) rst_cnt <= rst_cnt + 1;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] sv(logic e, logic [1:0] w, p, logic a);
    return {wdg_pkg::SETUP_FIXED_HI, e, w, p, a};
  endfunction
  function automatic logic [7:0] st(logic ovf, logic win, logic run);
    return {wdg_pkg::STATE_FIXED_HI, ovf, win, run};
  endfunction
  // ==========================================================
  // bus cycles and comparisons
  task automatic bus(logic wr, logic [15:0] idx, logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {14'h0000, idx, 2'b00};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask
  task automatic cmp(string nm, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk(logic [15:0] idx, logic [7:0] exp);
    bus(1'b0, idx, 8'h00);
    cmp($sformatf("register %h", idx), {24'h00_0000, exp}, q);
    cmp("response", 32'h0000_0000, {31'h0, hresp});
  endtask
  task automatic stop_wdg();
    bus(1'b1, wdg_pkg::IDX_SETUP, 8'h00);
    bus(1'b1, wdg_pkg::IDX_CODE, wdg_pkg::CODE_DISABLE);
  endtask
  task automatic wait_ev(bit rs, int lim);
    int s;
    s = rs ? rst_cnt : nmi_cnt;
    repeat (lim) begin
      @(posedge clk);
      if ((rs ? rst_cnt : nmi_cnt) != s) break;
    end
  endtask
  task automatic complete_run();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================================
  // scenarios
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    chk(wdg_pkg::IDX_SETUP, sv(1'b1, 2'b00, 2'b11, 1'b0));
    chk(wdg_pkg::IDX_STATE, st(1'b0, 1'b0, 1'b1));
    chk(wdg_pkg::IDX_CODE, 8'h00);
    chk(wdg_pkg::IDX_COUNT, 8'h00);
    chk(16'h0040, 8'h00);
    v = xs();
    bus(1'b1, wdg_pkg::IDX_SETUP, {3'b001, v[4:0]});
    chk(wdg_pkg::IDX_SETUP, sv(1'b1, 2'b00, 2'b11, 1'b0));
    bus(1'b1, wdg_pkg::IDX_SETUP, 8'h00);
    chk(wdg_pkg::IDX_STATE, st(1'b0, 1'b0, 1'b1));
    bus(1'b1, wdg_pkg::IDX_CODE, wdg_pkg::CODE_DISABLE);
    chk(wdg_pkg::IDX_STATE, st(1'b0, 1'b0, 1'b0));
    cmp("running pin", 32'h0000_0000, {31'h0, running});
    repeat (3) begin
      v = xs();
      bus(1'b1, wdg_pkg::IDX_CODE, v[7:0]);
      chk(wdg_pkg::IDX_STATE, st(1'b0, 1'b0, 1'b0));
    end
    bus(1'b1, wdg_pkg::IDX_SETUP, sv(1'b1, 2'b00, 2'b00, 1'b0));
    chk(wdg_pkg::IDX_SETUP, sv(1'b1, 2'b00, 2'b00, 1'b0));
    cmp("running pin", 32'h0000_0001, {31'h0, running});
    wait_ev(1'b0, 8400);
    wait_ev(1'b0, 8400);
    cmp("interrupt spacing", 32'h0000_2000, 32'(gap));
    chk(wdg_pkg::IDX_STATE, st(1'b1, 1'b0, 1'b1));
    chk(wdg_pkg::IDX_STATE, st(1'b0, 1'b0, 1'b1));
    bus(1'b1, wdg_pkg::IDX_CODE, wdg_pkg::CODE_CLEAR);
    chk(wdg_pkg::IDX_COUNT, 8'h00);
    stop_wdg();
    bus(1'b1, wdg_pkg::IDX_SETUP, sv(1'b1, 2'b11, 2'b00, 1'b0));
    n0 = nmi_cnt;
    bus(1'b1, wdg_pkg::IDX_CODE, wdg_pkg::CODE_CLEAR);
    repeat (4) @(posedge clk);
    cmp("early clear interrupts", 32'(n0 + 1), 32'(nmi_cnt));
    chk(wdg_pkg::IDX_STATE, st(1'b0, 1'b1, 1'b1));
    stop_wdg();
    bus(1'b1, wdg_pkg::IDX_SETUP, sv(1'b1, 2'b00, 2'b00, 1'b1));
    n0 = nmi_cnt;
    wait_ev(1'b1, 8400);
    cmp("reset requests", 32'h0000_0001, 32'(rst_cnt));
    cmp("interrupts", 32'(n0), 32'(nmi_cnt));
    hold <= 1'b1;
    bus(1'b0, wdg_pkg::IDX_COUNT, 8'h00);
    v = q;
    repeat (300) @(posedge clk);
    chk(wdg_pkg::IDX_COUNT, v[7:0]);
    hold <= 1'b0;
    repeat (300) @(posedge clk);
    bus(1'b0, wdg_pkg::IDX_COUNT, 8'h00);
    cmp("count resumes", 32'h0000_0001, {31'h0, q[7:0] != v[7:0]});
    stop_wdg();
    slow_sel <= 1'b0;
    bus(1'b1, wdg_pkg::IDX_SETUP, sv(1'b1, 2'b00, 2'b00, 1'b0));
    bus(1'b1, wdg_pkg::IDX_CODE, wdg_pkg::CODE_CLEAR);
    repeat (1100) @(posedge clk);
    chk(wdg_pkg::IDX_COUNT, 8'h01);
    complete_run();
  end
  // a hang in any wait ends the run as a failure
  initial begin
    repeat (60000) @(posedge clk);
    err_total++;
    complete_run();
  end
endmodule
`default_nettype wire
